/* verilog/tpg_pkg.sv */
// Shared constants and carriers of the three-port GPIO block
`default_nettype none

package tpg_pkg;

  // ****************************************
  // Pin layout
  // ****************************************
  localparam int NPIN = 18;            // 8 + 6 + 4 pins, flat index
  localparam logic [1:0] PORT0 = 2'h0;
  localparam logic [1:0] PORT1 = 2'h1;
  localparam logic [1:0] PORT2 = 2'h2;

  // ****************************************
  // Register addresses on the SFR bus
  // ****************************************
  localparam logic [7:0] P0_DATA   = 8'h80;
  localparam logic [7:0] P1_DATA   = 8'h88;
  localparam logic [7:0] P2_DATA   = 8'h90;
  localparam logic [7:0] P0_DIR    = 8'h91;
  localparam logic [7:0] P0_OD     = 8'h92;
  localparam logic [7:0] P0_PU     = 8'h93;
  localparam logic [7:0] P0_FSEL_L = 8'h94;
  localparam logic [7:0] P0_FSEL_H = 8'h95;
  localparam logic [7:0] P0_DBEN   = 8'h96;
  localparam logic [7:0] P1_DIR    = 8'h99;
  localparam logic [7:0] P1_OD     = 8'h9A;
  localparam logic [7:0] P1_PU     = 8'h9B;
  localparam logic [7:0] P1_FSEL_L = 8'h9C;
  localparam logic [7:0] P1_FSEL_H = 8'h9D;
  localparam logic [7:0] P12_DBEN  = 8'h9E;
  localparam logic [7:0] P2_DIR    = 8'hA1;
  localparam logic [7:0] P2_OD     = 8'hD2;
  localparam logic [7:0] P2_PU     = 8'hD3;
  localparam logic [7:0] P2_FSEL   = 8'hD4;

  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [7:0]  REG_RST   = 8'h00;
  localparam logic [17:0] VEC_RST   = 18'h00000;
  localparam logic [17:0] DB_MASK   = 18'h0D2C3; // Filter-capable pins
  localparam int          DBCLK_LSB = 4;         // Clock select in P0_DBEN
  localparam logic [1:0]  FILT_LAST = 2'h2;      // Third differing sample
  localparam logic [5:0]  DIV_RST   = 6'h00;

  // Debounce sampling clock choices
  typedef enum logic [1:0] {
    DIV1,
    DIV4,
    DIV16,
    DIV64
  } tpg_dbclk_e;

  // SFR bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } tpg_sfr_s;

  // Pad drive bundle, one bit per pin
  typedef struct packed {
    logic [17:0] out;
    logic [17:0] oe;
    logic [17:0] pu;
  } tpg_pad_s;

endpackage : tpg_pkg

`default_nettype wire

/* verilog/tpg_gpio.sv */
// Three-port GPIO block: SFR registers, pad control, debounce, events
//
// Behaviour
// - Three ports of 8, 6 and 4 pins, each pin set up alone.
// - Direction bit 0 makes the pin input, 1 makes it output.
// - An output pin drives the value written to its data bit.
// - Reading data returns the pin level for input pins.
// - Direction resets to input except pins chosen as reset outputs.
// - Pull-up bit 1 enables the pin pull-up, 0 disables it.
// - Reset clears every pull-up bit.
// - Open-drain bit 0 gives push-pull, 1 gives open-drain output.
// - Output type resets push-pull except pins chosen as open-drain.
// - Filter exists only on P0 0,1,6,7, P1 1,4, P2 0,1.
// - Sampling clock is system clock divided by 1, 4, 16 or 64.
// - A new level counts only after three equal consecutive samples.
// - Filter is bypassed in stop mode and resumes on release.
// - Reset clears all function select registers to normal I/O.
// - Pins of all ports flag pin state changes for interrupts.
// - Port 0 interrupt functions work only on input pins.
// - Port 1 interrupts, event counts, slave select need input pins.
// - Port 2 interrupt and event count work only on input pins.
`default_nettype none

module tpg_gpio #(
  parameter logic [17:0] DIR_RST = tpg_pkg::VEC_RST, // Pins reset as outputs
  parameter logic [17:0] OD_RST  = tpg_pkg::VEC_RST  // Pins reset open-drain
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire tpg_pkg::tpg_sfr_s sfr,
  output var  logic [7:0]       sfrRdata,
  input  wire logic             stopMode,
  input  wire logic [17:0]      padIn,
  input  wire logic [17:0]      altOut,
  input  wire logic [17:0]      altOe,
  output var  tpg_pkg::tpg_pad_s pad,
  output var  logic [17:0]      altActive,
  output var  logic [17:0]      pinLevel,
  output var  logic [17:0]      pinChange
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Replace one port's slice of a flat pin vector
  function automatic logic [17:0] setPort(input logic [17:0] v,
                                          input logic [1:0]  p,
                                          input logic [7:0]  w);
    logic [17:0] r;
    r = v;
    case (p)
      tpg_pkg::PORT0: r[7:0] = w;
      tpg_pkg::PORT1: r[13:8] = w[5:0];
      default:        r[17:14] = w[3:0];
    endcase
    return r;
  endfunction : setPort

  // Read one port's slice, unused upper bits as zero
  function automatic logic [7:0] getPort(input logic [17:0] v,
                                         input logic [1:0]  p);
    logic [7:0] r;
    r = tpg_pkg::REG_RST;
    case (p)
      tpg_pkg::PORT0: r = v[7:0];
      tpg_pkg::PORT1: r[5:0] = v[13:8];
      default:        r[3:0] = v[17:14];
    endcase
    return r;
  endfunction : getPort

  // Sampling tick: low bits of the free divider all ones
  function automatic logic divTick(input logic [5:0] c,
                                   input tpg_pkg::tpg_dbclk_e s);
    logic t;
    case (s)
      tpg_pkg::DIV1:  t = 1'b1;
      tpg_pkg::DIV4:  t = &c[1:0];
      tpg_pkg::DIV16: t = &c[3:0];
      default:        t = &c;
    endcase
    return t;
  endfunction : divTick

  // ****************************************
  // Register state
  // ****************************************
  logic [17:0]         data;
  logic [17:0]         dir;
  logic [17:0]         od;
  logic [17:0]         pu;
  logic [17:0]         dbEn;
  tpg_pkg::tpg_dbclk_e dbClkSel;
  logic [7:0]          fsel0L;
  logic [7:0]          fsel0H;
  logic [7:0]          fsel1L;
  logic [7:0]          fsel1H;
  logic [7:0]          fsel2;
  logic [5:0]          divCnt;
  logic                tick;
  logic [17:0]         dbStable;
  logic [1:0]          dbCnt [tpg_pkg::NPIN];
  logic [17:0]         lvl;
  logic [17:0]         prevLvl;
  logic [17:0]         altSel;
  logic [17:0]         portView;
  logic [39:0]         fselCat;
  logic                wr;

  assign wr = sfr.we;

  // Data latches; the written value is kept even for input pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data <= tpg_pkg::VEC_RST;
    end else if (wr) begin
      case (sfr.addr)
        tpg_pkg::P0_DATA: data <= setPort(data, tpg_pkg::PORT0, sfr.wdata);
        tpg_pkg::P1_DATA: data <= setPort(data, tpg_pkg::PORT1, sfr.wdata);
        tpg_pkg::P2_DATA: data <= setPort(data, tpg_pkg::PORT2, sfr.wdata);
        default: ;
      endcase
    end
  end

  // Direction bits, per-pin reset values from the parameter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dir <= DIR_RST;
    end else if (wr) begin
      case (sfr.addr)
        tpg_pkg::P0_DIR: dir <= setPort(dir, tpg_pkg::PORT0, sfr.wdata);
        tpg_pkg::P1_DIR: dir <= setPort(dir, tpg_pkg::PORT1, sfr.wdata);
        tpg_pkg::P2_DIR: dir <= setPort(dir, tpg_pkg::PORT2, sfr.wdata);
        default: ;
      endcase
    end
  end

  // Open-drain select bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      od <= OD_RST;
    end else if (wr) begin
      case (sfr.addr)
        tpg_pkg::P0_OD: od <= setPort(od, tpg_pkg::PORT0, sfr.wdata);
        tpg_pkg::P1_OD: od <= setPort(od, tpg_pkg::PORT1, sfr.wdata);
        tpg_pkg::P2_OD: od <= setPort(od, tpg_pkg::PORT2, sfr.wdata);
        default: ;
      endcase
    end
  end

  // Pull-up select bits, all off after reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pu <= tpg_pkg::VEC_RST;
    end else if (wr) begin
      case (sfr.addr)
        tpg_pkg::P0_PU: pu <= setPort(pu, tpg_pkg::PORT0, sfr.wdata);
        tpg_pkg::P1_PU: pu <= setPort(pu, tpg_pkg::PORT1, sfr.wdata);
        tpg_pkg::P2_PU: pu <= setPort(pu, tpg_pkg::PORT2, sfr.wdata);
        default: ;
      endcase
    end
  end

  // Debounce enables; bits of pins without a filter never stick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dbEn     <= tpg_pkg::VEC_RST;
      dbClkSel <= tpg_pkg::DIV1;
    end else if (wr && sfr.addr == tpg_pkg::P0_DBEN) begin
      dbEn[7:0] <= sfr.wdata & tpg_pkg::DB_MASK[7:0];
      dbClkSel  <= tpg_pkg::tpg_dbclk_e'(sfr.wdata[tpg_pkg::DBCLK_LSB +: 2]);
    end else if (wr && sfr.addr == tpg_pkg::P12_DBEN) begin
      dbEn[15:8] <= sfr.wdata & tpg_pkg::DB_MASK[15:8];
    end
  end

  // Function selects, cleared so every pin starts as plain I/O
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fsel0L <= tpg_pkg::REG_RST;
      fsel0H <= tpg_pkg::REG_RST;
      fsel1L <= tpg_pkg::REG_RST;
      fsel1H <= tpg_pkg::REG_RST;
      fsel2  <= tpg_pkg::REG_RST;
    end else if (wr) begin
      case (sfr.addr)
        tpg_pkg::P0_FSEL_L: fsel0L <= sfr.wdata;
        tpg_pkg::P0_FSEL_H: fsel0H <= sfr.wdata;
        tpg_pkg::P1_FSEL_L: fsel1L <= sfr.wdata;
        tpg_pkg::P1_FSEL_H: fsel1H <= sfr.wdata;
        tpg_pkg::P2_FSEL:   fsel2  <= sfr.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Function select decode
  // ****************************************

  // Two bits per pin; any non-zero field hands the pad to a peripheral
  assign fselCat = {fsel2, fsel1H, fsel1L, fsel0H, fsel0L};
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      altSel[i] = |fselCat[2 * i +: 2];
    end
    for (int i = 0; i < 6; i++) begin
      altSel[8 + i] = |fselCat[16 + 2 * i +: 2];
    end
    for (int i = 0; i < 4; i++) begin
      altSel[14 + i] = |fselCat[32 + 2 * i +: 2];
    end
  end

  // ****************************************
  // Debounce filter
  // ****************************************

  // Free-running divider; one shared tick paces every filter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divCnt <= tpg_pkg::DIV_RST;
    end else begin
      divCnt <= divCnt + 6'h01;
    end
  end
  assign tick = divTick(divCnt, dbClkSel);

  // Accept a new level on the third differing sample in a row; a pulse
  // shorter than three ticks is dropped, which the board must respect
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < tpg_pkg::NPIN; i++) begin
      if (rst) begin
        dbStable[i] <= 1'b0;
        dbCnt[i]    <= 2'h0;
      end else if (stopMode || !tpg_pkg::DB_MASK[i]) begin
        dbStable[i] <= padIn[i];
        dbCnt[i]    <= 2'h0;
      end else if (tick) begin
        if (padIn[i] == dbStable[i]) begin
          dbCnt[i] <= 2'h0;
        end else if (dbCnt[i] == tpg_pkg::FILT_LAST) begin
          dbStable[i] <= padIn[i];
          dbCnt[i]    <= 2'h0;
        end else begin
          dbCnt[i] <= dbCnt[i] + 2'h1;
        end
      end
    end
  end

  // Filtered level where enabled, raw pin elsewhere and in stop mode
  assign lvl = (dbEn & tpg_pkg::DB_MASK & {18{!stopMode}} & dbStable) |
               (~(dbEn & tpg_pkg::DB_MASK & {18{!stopMode}}) & padIn);

  // ****************************************
  // Pads and peripheral side
  // ****************************************

  // Open-drain outputs only pull low, so a 1 releases the pad
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pad       <= '0;
      altActive <= tpg_pkg::VEC_RST;
    end else begin
      pad.out   <= (altSel & altOut) | (~altSel & data & ~od);
      pad.oe    <= (altSel & altOe) |
                   (~altSel & dir & ~(od & data));
      pad.pu    <= pu;
      altActive <= altSel;
    end
  end

  // Level and change flags reach peripherals only from input pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prevLvl   <= tpg_pkg::VEC_RST;
      pinLevel  <= tpg_pkg::VEC_RST;
      pinChange <= tpg_pkg::VEC_RST;
    end else begin
      prevLvl   <= lvl;
      pinLevel  <= lvl & ~dir;
      pinChange <= (lvl ^ prevLvl) & ~dir;
    end
  end

  // ****************************************
  // SFR read port
  // ****************************************

  // Output pins read back their latch, input pins their level
  assign portView = (dir & data) | (~dir & lvl);

  // Registered read; unmapped addresses answer zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sfrRdata <= tpg_pkg::REG_RST;
    end else if (sfr.re) begin
      case (sfr.addr)
        tpg_pkg::P0_DATA:   sfrRdata <= getPort(portView, tpg_pkg::PORT0);
        tpg_pkg::P1_DATA:   sfrRdata <= getPort(portView, tpg_pkg::PORT1);
        tpg_pkg::P2_DATA:   sfrRdata <= getPort(portView, tpg_pkg::PORT2);
        tpg_pkg::P0_DIR:    sfrRdata <= getPort(dir, tpg_pkg::PORT0);
        tpg_pkg::P1_DIR:    sfrRdata <= getPort(dir, tpg_pkg::PORT1);
        tpg_pkg::P2_DIR:    sfrRdata <= getPort(dir, tpg_pkg::PORT2);
        tpg_pkg::P0_OD:     sfrRdata <= getPort(od, tpg_pkg::PORT0);
        tpg_pkg::P1_OD:     sfrRdata <= getPort(od, tpg_pkg::PORT1);
        tpg_pkg::P2_OD:     sfrRdata <= getPort(od, tpg_pkg::PORT2);
        tpg_pkg::P0_PU:     sfrRdata <= getPort(pu, tpg_pkg::PORT0);
        tpg_pkg::P1_PU:     sfrRdata <= getPort(pu, tpg_pkg::PORT1);
        tpg_pkg::P2_PU:     sfrRdata <= getPort(pu, tpg_pkg::PORT2);
        tpg_pkg::P0_FSEL_L: sfrRdata <= fsel0L;
        tpg_pkg::P0_FSEL_H: sfrRdata <= fsel0H;
        tpg_pkg::P1_FSEL_L: sfrRdata <= fsel1L;
        tpg_pkg::P1_FSEL_H: sfrRdata <= fsel1H;
        tpg_pkg::P2_FSEL:   sfrRdata <= fsel2;
        tpg_pkg::P0_DBEN:   sfrRdata <= {dbEn[7:6], dbClkSel, dbEn[3:0]};
        tpg_pkg::P12_DBEN:  sfrRdata <= dbEn[15:8];
        default:            sfrRdata <= tpg_pkg::REG_RST;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_read_p0;
    sfr.re && sfr.addr == tpg_pkg::P0_DATA;
  endsequence

  sequence s_div4_tick;
    tick && dbClkSel == tpg_pkg::DIV4;
  endsequence

  a_input_no_drive: assert property (
    1'b1 |=> ((pad.oe & ~$past(altSel | dir)) == 18'h00000))
    else $error("input pin is driven");

  a_output_value: assert property (
    1'b1 |=> (((pad.out ^ $past(data)) & $past(dir & ~od & ~altSel))
              == 18'h00000))
    else $error("output pin does not follow its data bit");

  a_opendrain_release: assert property (
    1'b1 |=> ((pad.oe & $past(od & data & ~altSel)) == 18'h00000))
    else $error("open-drain pin drives a high level");

  a_read_level: assert property (
    s_read_p0 |=> sfrRdata == $past(portView[7:0]))
    else $error("port 0 read shows wrong levels");

  a_pullup_follow: assert property (
    1'b1 |=> pad.pu == $past(pu))
    else $error("pull-up output does not follow its register");

  a_reset_clear: assert property (
    $fell(rst) |-> (pu == 18'h00000 && fselCat == 40'h0000000000))
    else $error("pull-up or function select not cleared by reset");

  a_div4_spacing: assert property (
    s_div4_tick |-> $past(divCnt[1:0]) == 2'h2 ##1 !tick [*3])
    else $error("divide-by-4 tick spacing wrong");

  a_stop_bypass: assert property (
    stopMode |-> lvl == padIn ##1
      ((dbStable ^ $past(padIn)) & tpg_pkg::DB_MASK) == 18'h00000)
    else $error("filter active or not reloaded in stop mode");

  a_event_input: assert property (
    1'b1 |=> ((pinChange & $past(dir)) == 18'h00000))
    else $error("change flagged on an output pin");

  a_filter_accept: assert property (
    !stopMode && $past(!stopMode) && $changed(dbStable & tpg_pkg::DB_MASK)
    |-> $past(tick))
    else $error("filtered level changed without a sample");

endmodule : tpg_gpio

`default_nettype wire

/* verif/tpg_board.sv */
// Board model: resolves each pad wire from chip, board driver and pull-up
`default_nettype none

module tpg_board (
  input  wire logic              clk_sys,
  input  wire tpg_pkg::tpg_pad_s pad,
  input  wire logic [17:0]       extEn,
  input  wire logic [17:0]       extVal,
  output var  logic [17:0]       padIn
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [17:0] lastLevel = 18'h00000;

  // ****************************************
  // Wire resolution
  // ****************************************
  // A released wire with no pull-up drifts every cycle, never holds
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      if (pad.oe[i]) begin
        padIn[i] = pad.out[i];
      end else if (extEn[i]) begin
        padIn[i] = extVal[i];
      end else if (pad.pu[i]) begin
        padIn[i] = 1'b1;
      end else begin
        padIn[i] = ~lastLevel[i];
      end
    end
  end

  // Last wire level, used for the drifting float
  always @(posedge clk_sys) begin
    lastLevel <= padIn;
  end

endmodule : tpg_board

`default_nettype wire

/* verif/tpg_gpio_test.sv */
// Self-checking bench of the three-port GPIO block
`default_nettype none

module tpg_gpio_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic              clk_sys = 1'b0;
  logic              rst;
  tpg_pkg::tpg_sfr_s sfr;
  logic [7:0]        sfrRdata;
  logic              stopMode;
  logic [17:0]       padIn;
  logic [17:0]       altOut;
  logic [17:0]       altOe;
  logic [17:0]       altActive;
  logic [17:0]       pinLevel;
  logic [17:0]       pinChange;
  logic [17:0]       extEn;
  logic [17:0]       extVal;
  tpg_pkg::tpg_pad_s pad;
  int                fails;
  int                num_checks;
  logic [7:0]        rv;
  logic [17:0]       acc;
  logic              hit;

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  tpg_gpio u_dut (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .sfr       (sfr),
    .sfrRdata  (sfrRdata),
    .stopMode  (stopMode),
    .padIn     (padIn),
    .altOut    (altOut),
    .altOe     (altOe),
    .pad       (pad),
    .altActive (altActive),
    .pinLevel  (pinLevel),
    .pinChange (pinChange)
  );

  tpg_board u_board (
    .clk_sys (clk_sys),
    .pad     (pad),
    .extEn   (extEn),
    .extVal  (extVal),
    .padIn   (padIn)
  );

  // ****************************************
  // Bus and check helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [17:0] seen,
                       input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Strobe drops for a cycle so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr.addr  = a;
    sfr.wdata = d;
    sfr.we    = 1'b1;
    tick(1);
    sfr.we = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    sfr.addr = a;
    sfr.re   = 1'b1;
    tick(1);
    sfr.re = 1'b0;
    tick(1);
    rv = sfrRdata;
  endtask : rd

  task automatic watch(input int n);
    acc = '0;
    repeat (n) begin
      tick(1);
      acc = acc | pinChange;
    end
  endtask : watch

  // Pulse on P0.0 for n cycles, then m quiet cycles; hit if any change
  task automatic pulse(input int n, input int m);
    extVal[0] = 1'b1;
    watch(n);
    hit = acc[0];
    extVal[0] = 1'b0;
    watch(m);
    hit = hit | acc[0];
  endtask : pulse

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] regs [17];
    regs = '{tpg_pkg::P0_DIR, tpg_pkg::P0_OD, tpg_pkg::P0_PU,
             tpg_pkg::P0_FSEL_L, tpg_pkg::P0_FSEL_H, tpg_pkg::P0_DBEN,
             tpg_pkg::P1_DIR, tpg_pkg::P1_OD, tpg_pkg::P1_PU,
             tpg_pkg::P1_FSEL_L, tpg_pkg::P1_FSEL_H, tpg_pkg::P12_DBEN,
             tpg_pkg::P2_DIR, tpg_pkg::P2_OD, tpg_pkg::P2_PU,
             tpg_pkg::P2_FSEL, 8'h81};
    check("reset oe", pad.oe, 18'h00000);
    check("reset pu", pad.pu, 18'h00000);
    foreach (regs[i]) begin
      rd(regs[i]);
      check("reset reg", rv, 8'h00);
    end
    wr(8'h81, 8'hFF);
    rd(8'h81);
    check("unmapped", rv, 8'h00);
  endtask : t_reset

  task automatic t_output;
    wr(tpg_pkg::P0_DIR, 8'hFF);
    wr(tpg_pkg::P1_DIR, 8'hFF);
    wr(tpg_pkg::P2_DIR, 8'hFF);
    wr(tpg_pkg::P0_DATA, 8'hA5);
    wr(tpg_pkg::P1_DATA, 8'hFF);
    wr(tpg_pkg::P2_DATA, 8'hF6);
    tick(1);
    check("out oe", pad.oe, 18'h3FFFF);
    check("out val", pad.out, 18'h1BFA5);
    rd(tpg_pkg::P1_DATA);
    check("p1 latch", rv, 8'h3F);
    rd(tpg_pkg::P2_DATA);
    check("p2 latch", rv, 8'h06);
    wr(tpg_pkg::P0_DATA, 8'h5A);
    watch(4);
    check("out events", acc, 18'h00000);
    check("out level", pinLevel, 18'h00000);
    wr(tpg_pkg::P0_OD, 8'h01);
    tick(1);
    check("od low", {pad.oe[0], pad.out[0]}, 2'b10);
    wr(tpg_pkg::P0_DATA, 8'h5B);
    tick(1);
    check("od high", pad.oe[0], 1'b0);
    wr(tpg_pkg::P0_OD, 8'h00);
    tick(1);
    check("push pull", {pad.oe[0], pad.out[0]}, 2'b11);
    wr(tpg_pkg::P2_OD, 8'h0F);
    tick(1);
    check("p2 od", pad.oe[17:14], 4'h9);
  endtask : t_output

  task automatic t_input;
    wr(tpg_pkg::P0_DIR, 8'h00);
    wr(tpg_pkg::P1_DIR, 8'h00);
    wr(tpg_pkg::P2_DIR, 8'h00);
    watch(6);
    extVal = 18'h2953C;
    watch(4);
    check("rise events", acc, 18'h2953C);
    rd(tpg_pkg::P0_DATA);
    check("p0 in", rv, 8'h3C);
    rd(tpg_pkg::P1_DATA);
    check("p1 in", rv, 8'h15);
    rd(tpg_pkg::P2_DATA);
    check("p2 in", rv, 8'h0A);
    extVal = 18'h00000;
    watch(4);
    check("fall events", acc, 18'h2953C);
  endtask : t_input

  task automatic t_pullup;
    extEn = 18'h3FF00;
    wr(tpg_pkg::P0_PU, 8'hF0);
    wr(tpg_pkg::P1_PU, 8'hFF);
    wr(tpg_pkg::P2_PU, 8'hFF);
    tick(1);
    check("pu on", pad.pu, 18'h3FFF0);
    rd(tpg_pkg::P0_DATA);
    check("pulled", rv & 8'hF0, 8'hF0);
    rd(tpg_pkg::P1_PU);
    check("p1 pu rd", rv, 8'h3F);
    wr(tpg_pkg::P0_PU, 8'h00);
    wr(tpg_pkg::P1_PU, 8'h00);
    wr(tpg_pkg::P2_PU, 8'h00);
    tick(1);
    check("pu off", pad.pu, 18'h00000);
    extEn = 18'h3FFFF;
  endtask : t_pullup

  task automatic t_altfunc;
    altOut = 18'h0000A;
    altOe  = 18'h0000F;
    wr(tpg_pkg::P0_FSEL_L, 8'h55);
    wr(tpg_pkg::P1_FSEL_L, 8'h01);
    wr(tpg_pkg::P1_FSEL_H, 8'h04);
    wr(tpg_pkg::P2_FSEL, 8'h40);
    tick(1);
    check("alt on", altActive, 18'h2210F);
    check("alt pad", {pad.oe[3:0], pad.out[3:0]}, 8'hFA);
    wr(tpg_pkg::P0_FSEL_L, 8'h00);
    wr(tpg_pkg::P1_FSEL_L, 8'h00);
    wr(tpg_pkg::P1_FSEL_H, 8'h00);
    wr(tpg_pkg::P2_FSEL, 8'h00);
    tick(1);
    check("alt off", altActive, 18'h00000);
  endtask : t_altfunc

  // Every sampling rate: short glitch dropped, steady level timed
  task automatic t_debounce;
    int div;
    int lat;
    for (int d = 0; d < 4; d++) begin
      div = 1 << (2 * d);
      wr(tpg_pkg::P0_DBEN, 8'h01 | 8'(d << 4));
      watch(8);
      pulse(2 * div, 3 * div + 8);
      check("glitch", hit, 1'b0);
      extVal[0] = 1'b1;
      lat = 0;
      while (pinLevel[0] !== 1'b1) begin
        lat++;
        if (lat > 300) begin
          fails++;
          test_done;
        end
        tick(1);
      end
      check("latency", lat > 2 * div && lat <= 3 * div + 4, 1'b1);
      extVal[0] = 1'b0;
      watch(3 * div + 8);
    end
  endtask : t_debounce

  task automatic t_bypass;
    wr(tpg_pkg::P0_DBEN, 8'h34);
    rd(tpg_pkg::P0_DBEN);
    check("db0 bits", rv, 8'h30);
    wr(tpg_pkg::P12_DBEN, 8'hFF);
    rd(tpg_pkg::P12_DBEN);
    check("db12 bits", rv, 8'hD2);
    pulse(1, 4);
    check("no filter", hit, 1'b1);
    wr(tpg_pkg::P0_DBEN, 8'h31);
    stopMode = 1'b1;
    tick(2);
    pulse(1, 4);
    check("stop raw", hit, 1'b1);
    stopMode = 1'b0;
    tick(2);
    pulse(2, 200);
    check("resumed", hit, 1'b0);
  endtask : t_bypass

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    fails      = 0;
    num_checks = 0;
    rst        = 1'b1;
    sfr        = '0;
    stopMode   = 1'b0;
    altOut     = 18'h00000;
    altOe      = 18'h00000;
    extEn      = 18'h3FFFF;
    extVal     = 18'h00000;
    tick(20);
    rst = 1'b0;
    t_reset();
    t_output();
    t_input();
    t_pullup();
    t_altfunc();
    t_debounce();
    t_bypass();
    test_done();
  end

endmodule : tpg_gpio_test

`default_nettype wire
